// ### logic/lsrh_regs.v
`timescale 1ns/100ps
`include "lsrh_map.vh"

// Summary of operation
// - Start a low-speed transaction only when frame time left >= threshold.
// - Threshold decides if an eight-byte low-speed packet fits before frame end.
// - Top byte gives power-good delay in 2 ms units; software waits that long.
// - Overcurrent-absent bit set means no overcurrent protection.
// - Overcurrent mode 0 reports globally, 1 per port, if protection exists.
// - Reset loads overcurrent mode from the power switching mode bit.
// - Compound flag always reads 0 and ignores writes.
// - Always-powered bit 1 keeps ports powered; 0 means ports are switched.
// - Switching mode 0 powers all ports together; 1 powers them individually.
// - In switching mode 1, masked ports obey per-port commands only; unmasked obey the global switch.
// - Downstream port count reads only, between 1 and 15.

module lsrh_regs
#(
  parameter [7:0] PORT_COUNT = `LSRH_PORT_CNT_RESET
)
(
  // Clock and reset
  input  wire        clk_in,
  input  wire        rst_n_in,
  // Register access
  input  wire [7:0]  reg_addr_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  input  wire [31:0] reg_wdata_in,
  output reg  [31:0] reg_rdata_out,
  // Frame timing and low-speed scheduling
  input  wire [13:0] frame_time_left_in,
  input  wire        frame_start_in,
  input  wire        ls_req_in,
  output wire        ls_start_out,
  output wire        ls_deferred_out,
  // Root hub power control
  input  wire [15:0] port_power_mask_in,
  input  wire        global_power_set_in,
  input  wire        global_power_clr_in,
  input  wire [15:0] port_power_set_in,
  input  wire [15:0] port_power_clr_in,
  output reg  [15:0] port_power_out,
  // Overcurrent handling
  input  wire [15:0] port_overcurrent_in,
  output reg  [15:0] overcurrent_report_out,
  // Power-good wait
  output reg         power_good_wait_out
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg  [11:0] lowspeed_commit_limit_reg;
  reg  [7:0]  power_good_delay_reg;
  reg         overcurrent_absent_reg;
  reg         overcurrent_report_mode_reg;
  reg         always_powered_reg;
  reg         switching_mode_reg;
  reg         global_power_reg;
  reg  [15:0] port_power_reg;
  reg  [23:0] pg_cnt_reg;
  reg  [7:0]  pg_units_reg;
  reg  [15:0] port_power_reg_prev;

  wire [7:0]  downstream_port_count;
  wire [15:0] port_exists;
  wire        wr_limit;
  wire        wr_rha;
  wire        any_power_on;

  // Clamp the port count to the legal range
  assign downstream_port_count = (PORT_COUNT < `LSRH_PORT_CNT_MIN) ? `LSRH_PORT_CNT_MIN :
                                 (PORT_COUNT > `LSRH_PORT_CNT_MAX) ? `LSRH_PORT_CNT_MAX :
                                 PORT_COUNT;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_exist
      // Bit 0 is reserved; ports are numbered from 1
      assign port_exists[gi] = (gi != 0) && (gi <= downstream_port_count);
    end
  endgenerate

  assign wr_limit = reg_wr_in && (reg_addr_in == `LSRH_OFS_LS_THRESH);
  assign wr_rha = reg_wr_in && (reg_addr_in == `LSRH_OFS_RH_DESC_A);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Reserved bits are dropped on write; software is expected to keep them at reset values
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      lowspeed_commit_limit_reg   <= `LSRH_LIMIT_RESET;
      power_good_delay_reg        <= `LSRH_PG_DELAY_RESET;
      overcurrent_absent_reg      <= `LSRH_OC_ABSENT_RESET;
      overcurrent_report_mode_reg <= `LSRH_SW_MODE_RESET;
      always_powered_reg          <= `LSRH_ALWAYS_PWR_RESET;
      switching_mode_reg          <= `LSRH_SW_MODE_RESET;
    end
    else
    begin
      if (wr_limit)
        lowspeed_commit_limit_reg <= reg_wdata_in[`LSRH_LIMIT_MSB:0];
      if (wr_rha)
      begin
        power_good_delay_reg        <= reg_wdata_in[`LSRH_PG_DELAY_MSB:`LSRH_PG_DELAY_LSB];
        overcurrent_absent_reg      <= reg_wdata_in[`LSRH_OC_ABSENT_BIT];
        overcurrent_report_mode_reg <= reg_wdata_in[`LSRH_OC_MODE_BIT];
        always_powered_reg          <= reg_wdata_in[`LSRH_ALWAYS_PWR_BIT];
        switching_mode_reg          <= reg_wdata_in[`LSRH_SW_MODE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always @*
  begin
    reg_rdata_out = 32'h0000_0000;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `LSRH_OFS_LS_THRESH:
          reg_rdata_out = {20'h00000, lowspeed_commit_limit_reg};
        `LSRH_OFS_RH_DESC_A:
          reg_rdata_out = {power_good_delay_reg, 11'h000, overcurrent_absent_reg,
                           overcurrent_report_mode_reg, 1'b0,
                           always_powered_reg, switching_mode_reg,
                           downstream_port_count};
        default:
          reg_rdata_out = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Low-speed commit decision
  // ----------------------------------------------------------------
  lsrh_commit_gate u_gate
  (
    .clk_in             (clk_in),
    .rst_n_in           (rst_n_in),
    .limit_in           (lowspeed_commit_limit_reg),
    .frame_time_left_in (frame_time_left_in),
    .frame_start_in     (frame_start_in),
    .ls_req_in          (ls_req_in),
    .ls_start_out       (ls_start_out),
    .ls_deferred_out    (ls_deferred_out)
  );

  // ----------------------------------------------------------------
  // Port power switching
  // ----------------------------------------------------------------
  integer pi;
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      global_power_reg <= 1'b0;
      port_power_reg   <= 16'h0000;
    end
    else
    begin
      if (global_power_set_in)
        global_power_reg <= 1'b1;
      else if (global_power_clr_in)
        global_power_reg <= 1'b0;
      for (pi = 0; pi < 16; pi = pi + 1)
      begin
        if (port_power_set_in[pi])
          port_power_reg[pi] <= 1'b1;
        else if (port_power_clr_in[pi])
          port_power_reg[pi] <= 1'b0;
      end
    end
  end

  always @(posedge clk_in)
  begin
    if (!rst_n_in)
      port_power_out <= 16'h0000;
    else if (always_powered_reg)
      port_power_out <= port_exists;
    else if (!switching_mode_reg)
      port_power_out <= port_exists & {16{global_power_reg}};
    else
      port_power_out <= port_exists & ((port_power_mask_in & port_power_reg) |
                        (~port_power_mask_in & {16{global_power_reg}}));
  end

  // ----------------------------------------------------------------
  // Overcurrent reporting
  // ----------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
      overcurrent_report_out <= 16'h0000;
    else if (overcurrent_absent_reg)
      overcurrent_report_out <= 16'h0000;
    else if (!overcurrent_report_mode_reg)
      overcurrent_report_out <= port_exists & {16{|(port_overcurrent_in & port_exists)}};
    else
      overcurrent_report_out <= port_overcurrent_in & port_exists;
  end

  // ----------------------------------------------------------------
  // Power-good wait after ports come up
  // ----------------------------------------------------------------
  // Restarts on any port turning on; holds the wait flag for delay x 2 ms
  assign any_power_on = |(port_power_out & ~port_power_reg_prev);
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      port_power_reg_prev <= 16'h0000;
      pg_cnt_reg          <= 24'h000000;
      pg_units_reg        <= 8'h00;
      power_good_wait_out <= 1'b0;
    end
    else
    begin
      port_power_reg_prev <= port_power_out;
      if (any_power_on && power_good_delay_reg != 8'h00)
      begin
        pg_units_reg        <= power_good_delay_reg;
        pg_cnt_reg          <= 24'h000000;
        power_good_wait_out <= 1'b1;
      end
      else if (power_good_wait_out)
      begin
        if (pg_cnt_reg == `LSRH_PG_UNIT_CYC - 1)
        begin
          pg_cnt_reg <= 24'h000000;
          if (pg_units_reg == 8'h01)
            power_good_wait_out <= 1'b0;
          pg_units_reg <= pg_units_reg - 8'h01;
        end
        else
          pg_cnt_reg <= pg_cnt_reg + 24'h000001;
      end
    end
  end

endmodule // lsrh_regs

// ### pkg/lsrh_map.vh
`ifndef LSRH_MAP_VH
`define LSRH_MAP_VH

// Register offsets from the base address
`define LSRH_OFS_LS_THRESH    8'h44
`define LSRH_OFS_RH_DESC_A    8'h48

// Low-speed threshold register
`define LSRH_LIMIT_MSB        11
`define LSRH_LIMIT_RESET      12'h628
`define LSRH_FRAME_LEFT_W     14

// Root hub descriptor A fields
`define LSRH_PG_DELAY_MSB     31
`define LSRH_PG_DELAY_LSB     24
`define LSRH_OC_ABSENT_BIT    12
`define LSRH_OC_MODE_BIT      11
`define LSRH_COMPOUND_BIT     10
`define LSRH_ALWAYS_PWR_BIT   9
`define LSRH_SW_MODE_BIT      8
`define LSRH_PG_DELAY_RESET   8'hff
`define LSRH_OC_ABSENT_RESET  1'b0
`define LSRH_ALWAYS_PWR_RESET 1'b0
`define LSRH_SW_MODE_RESET    1'b1
`define LSRH_PORT_CNT_RESET   8'h02
`define LSRH_PORT_CNT_MIN     8'h01
`define LSRH_PORT_CNT_MAX     8'h0f

// Port count limit for the power mask
`define LSRH_PORTS_MAX        15

// Power-good unit in microseconds and in clock cycles at 40 MHz
`define LSRH_PG_UNIT_US       2000
`define LSRH_CLK_MHZ          40
`define LSRH_PG_UNIT_CYC      (`LSRH_PG_UNIT_US * `LSRH_CLK_MHZ)

`endif

// ### logic/lsrh_commit_gate.v
`timescale 1ns/100ps
`include "lsrh_map.vh"

module lsrh_commit_gate
(
  // Clock and reset
  input  wire        clk_in,
  input  wire        rst_n_in,
  // Threshold and frame time
  input  wire [11:0] limit_in,
  input  wire [13:0] frame_time_left_in,
  input  wire        frame_start_in,
  // Low-speed request
  input  wire        ls_req_in,
  output wire        ls_start_out,
  output reg         ls_deferred_out
);

  wire fits;

  // Zero-extend the threshold so the compare is at the frame counter's width
  assign fits = (frame_time_left_in >= {2'b00, limit_in});

  assign ls_start_out = ls_req_in & fits & ~ls_deferred_out;

  // A failed compare parks the request until the next frame begins;
  // a failure in the frame-start cycle itself still wins over the clear
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
      ls_deferred_out <= 1'b0;
    else if (ls_req_in && !fits)
      ls_deferred_out <= 1'b1;
    else if (frame_start_in)
      ls_deferred_out <= 1'b0;
  end

endmodule // lsrh_commit_gate

// ### tb/lsrh_regs_asserts.sv
`timescale 1ns/100ps
module lsrh_regs_asserts
#(
  parameter [7:0] PORT_COUNT = 8'h02
)
(
  // Clock and reset
  input wire        clk_in,
  input wire        rst_n_in,
  // Register access and design outputs
  input wire [7:0]  reg_addr_in,
  input wire        reg_wr_in,
  input wire        reg_rd_in,
  input wire [31:0] reg_wdata_in,
  input wire [31:0] reg_rdata_out,
  input wire [13:0] frame_time_left_in,
  input wire        frame_start_in,
  input wire        ls_req_in,
  input wire        ls_start_out,
  input wire        ls_deferred_out,
  input wire [15:0] port_power_out,
  input wire [15:0] overcurrent_report_out
);
  // Ports 1..PORT_COUNT exist; bit 0 is never a port
  localparam logic [15:0] PM = (16'h0001 << (PORT_COUNT + 8'h01)) - 16'h0002;
  logic [11:0] lim_q;
  logic        oc_absent_q;
  logic        always_pwr_q;
  logic        desc_wr_q;
  wire         desc_rd = reg_rd_in && reg_addr_in == 8'h48;

  // Shadow of the written fields, so outputs can be tied to their cause
  always_ff @(posedge clk_in)
    if (!rst_n_in)
    begin
      lim_q        <= 12'h628;
      oc_absent_q  <= 1'b0;
      always_pwr_q <= 1'b0;
      desc_wr_q    <= 1'b0;
    end
    else if (reg_wr_in && reg_addr_in == 8'h44)
      lim_q <= reg_wdata_in[11:0];
    else if (reg_wr_in && reg_addr_in == 8'h48)
    begin
      oc_absent_q  <= reg_wdata_in[12];
      always_pwr_q <= reg_wdata_in[9];
      desc_wr_q    <= 1'b1;
    end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence ls_refused;
    ls_req_in && !ls_start_out && !frame_start_in;
  endsequence

  ls_gate_a: assert property (ls_start_out == (ls_req_in && !ls_deferred_out
    && frame_time_left_in >= {2'b00, lim_q})) else $error("start gate wrong");
  defer_set_a: assert property (ls_refused |=> ls_deferred_out)
    else $error("refused request not deferred");
  defer_clr_a: assert property (frame_start_in && !ls_req_in |=> !ls_deferred_out)
    else $error("deferral not cleared");
  compound_zero_a: assert property (desc_rd |-> !reg_rdata_out[10])
    else $error("compound flag set");
  port_count_a: assert property (desc_rd |-> reg_rdata_out[7:0] == PORT_COUNT)
    else $error("port count wrong");
  report_mode_reset_a: assert property (desc_rd && !desc_wr_q |->
    reg_rdata_out[11] == reg_rdata_out[8]) else $error("report mode differs from switching mode");
  no_ocp_a: assert property (oc_absent_q |=> overcurrent_report_out == 16'h0000)
    else $error("overcurrent reported while absent");
  always_on_a: assert property (always_pwr_q |=> (port_power_out & PM) == PM)
    else $error("port unpowered in always-powered mode");
endmodule // lsrh_regs_asserts

bind lsrh_regs lsrh_regs_asserts #(.PORT_COUNT(PORT_COUNT)) i_chk
(
  .clk_in                 (clk_in),
  .rst_n_in               (rst_n_in),
  .reg_addr_in            (reg_addr_in),
  .reg_wr_in              (reg_wr_in),
  .reg_rd_in              (reg_rd_in),
  .reg_wdata_in           (reg_wdata_in),
  .reg_rdata_out          (reg_rdata_out),
  .frame_time_left_in     (frame_time_left_in),
  .frame_start_in         (frame_start_in),
  .ls_req_in              (ls_req_in),
  .ls_start_out           (ls_start_out),
  .ls_deferred_out        (ls_deferred_out),
  .port_power_out         (port_power_out),
  .overcurrent_report_out (overcurrent_report_out)
);

// ### tb/lowspeed_threshold_roothub_desc_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end

module lowspeed_threshold_roothub_desc_tb_top;
  logic        clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [7:0]  reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0, reg_rdata_out;
  logic [13:0] frame_time_left_in = '0;
  logic        frame_start_in = 1'b0, ls_req_in = 1'b0, ls_start_out, ls_deferred_out;
  logic        global_power_set_in = 1'b0, global_power_clr_in = 1'b0, power_good_wait_out;
  logic [15:0] port_power_mask_in = '0, port_power_set_in = '0, port_power_clr_in = '0;
  logic [15:0] port_power_out, port_overcurrent_in = '0, overcurrent_report_out;
  int          error_cnt = 0, num_checks = 0;
  logic [31:0] ocd [3] = '{32'h00000800, 32'h00000000, 32'h00001000};
  logic [15:0] oce [3] = '{16'h0004, 16'h0006, 16'h0000};

  lsrh_regs i_dut
  (
    .clk_in                 (clk_in),
    .rst_n_in               (rst_n_in),
    .reg_addr_in            (reg_addr_in),
    .reg_wr_in              (reg_wr_in),
    .reg_rd_in              (reg_rd_in),
    .reg_wdata_in           (reg_wdata_in),
    .reg_rdata_out          (reg_rdata_out),
    .frame_time_left_in     (frame_time_left_in),
    .frame_start_in         (frame_start_in),
    .ls_req_in              (ls_req_in),
    .ls_start_out           (ls_start_out),
    .ls_deferred_out        (ls_deferred_out),
    .port_power_mask_in     (port_power_mask_in),
    .global_power_set_in    (global_power_set_in),
    .global_power_clr_in    (global_power_clr_in),
    .port_power_set_in      (port_power_set_in),
    .port_power_clr_in      (port_power_clr_in),
    .port_power_out         (port_power_out),
    .port_overcurrent_in    (port_overcurrent_in),
    .overcurrent_report_out (overcurrent_report_out),
    .power_good_wait_out    (power_good_wait_out)
  );

  initial forever #12.5 clk_in = ~clk_in;

  // --------------------------------
  // Bus and control helpers
  // --------------------------------
  task automatic do_reset;
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in    <= 1'b0;
  endtask

  // Read data is combinational, so it is taken once the edge has settled
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    #1 d = reg_rdata_out;
  endtask

  task automatic pw(input logic gs, gc, input logic [15:0] ps, pc);
    @(posedge clk_in);
    {global_power_set_in, global_power_clr_in, port_power_set_in, port_power_clr_in} <=
      {gs, gc, ps, pc};
    @(posedge clk_in);
    {global_power_set_in, global_power_clr_in, port_power_set_in, port_power_clr_in} <= '0;
    // Commands landed at the last edge; the power outputs follow at this edge
    @(posedge clk_in);
    #1;
  endtask

  function automatic logic exp_start(logic [13:0] f, logic [11:0] l);
    return f >= {2'b00, l};
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clk_in);
    error_cnt++;
    tally_and_finish;
  end

  // --------------------------------
  // Scenarios
  // --------------------------------
  initial
  begin
    logic [31:0] d;
    logic [11:0] lim;
    logic [13:0] ftl;
    logic        ok;
    void'($urandom(32'h9996));
    do_reset;
    rd(8'h44, d); `CHK(d, 32'h00000628)
    rd(8'h48, d); `CHK(d, 32'hff000902)
    rd(8'h4c, d); `CHK(d, 32'h00000000)
    pw(1'b1, 1'b0, '0, '0); `CHK(port_power_out, 16'h0006)
    repeat (2) @(posedge clk_in);
    #1 `CHK(power_good_wait_out, 1'b1)
    do_reset;
    wr(8'h48, 32'h00000000);
    pw(1'b1, 1'b0, '0, '0); `CHK(port_power_out, 16'h0006)
    repeat (2) @(posedge clk_in);
    #1 `CHK(power_good_wait_out, 1'b0)
    pw(1'b0, 1'b1, '0, '0); `CHK(port_power_out, 16'h0000)
    @(posedge clk_in);
    port_power_mask_in <= 16'h0002;
    wr(8'h48, 32'h00000100);
    pw(1'b1, 1'b0, '0, '0); `CHK(port_power_out, 16'h0004)
    pw(1'b0, 1'b0, 16'h0002, '0); `CHK(port_power_out, 16'h0006)
    pw(1'b0, 1'b1, '0, '0); `CHK(port_power_out, 16'h0002)
    @(posedge clk_in);
    port_overcurrent_in <= 16'h0004;
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h48, ocd[i]);
      repeat (2) @(posedge clk_in);
      #1 `CHK(overcurrent_report_out, oce[i])
    end
    // Reserved bits 23:13 stay at their reset value of zero
    wr(8'h48, 32'hff001fff);
    rd(8'h48, d); `CHK(d, 32'hff001b02)
    `CHK(port_power_out, 16'h0006)
    // Equal and one-below cases first, then random thresholds and frame times
    for (int i = 0; i < 24; i++)
    begin
      lim = (i < 2) ? 12'h628 : 12'($urandom);
      ftl = (i == 0) ? 14'h0628 : (i == 1) ? 14'h0627 : 14'($urandom);
      wr(8'h44, {20'h00000, lim});
      rd(8'h44, d); `CHK(d, {20'h00000, lim})
      @(posedge clk_in);
      frame_start_in <= 1'b1;
      @(posedge clk_in);
      frame_start_in     <= 1'b0;
      ls_req_in          <= 1'b1;
      frame_time_left_in <= ftl;
      #1 ok = exp_start(ftl, lim);
      `CHK(ls_start_out, ok)
      @(posedge clk_in);
      frame_time_left_in <= 14'h3fff;
      #1 `CHK(ls_deferred_out, !ok)
      `CHK(ls_start_out, ok)
      @(posedge clk_in);
      ls_req_in <= 1'b0;
    end
    tally_and_finish;
  end
endmodule // lowspeed_threshold_roothub_desc_tb_top
